// *** aogtb_pkg.sv ***
// ****************************************************************
// Trim bank constants.
// ****************************************************************
package aogtb_pkg;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int OFS_W = 12;
  localparam int OFS_REG_W = 16;
  localparam int GAIN_W = 5;
  localparam int NUM_OFS = 2;
  localparam int NUM_GAIN = 8;
  // Byte addresses; each 16-bit offset register spans two bytes.
  localparam logic [11:0] OFS_INPUT_A_ADDR = 12'h034C;
  localparam logic [11:0] OFS_INPUT_B_ADDR = 12'h034E;
  localparam logic [11:0] GAIN_CA_B0_DUAL_ADDR = 12'h0350;
  localparam logic [11:0] GAIN_CA_B1_DUAL_ADDR = 12'h0351;
  localparam logic [11:0] GAIN_CB_B0_DUAL_ADDR = 12'h0352;
  localparam logic [11:0] GAIN_CB_B1_DUAL_ADDR = 12'h0353;
  localparam logic [11:0] GAIN_CA_B0_SINGLE_ADDR = 12'h0354;
  localparam logic [11:0] GAIN_CA_B1_SINGLE_ADDR = 12'h0355;
  localparam logic [11:0] GAIN_CB_B0_SINGLE_ADDR = 12'h0356;
  localparam logic [11:0] GAIN_CB_B1_SINGLE_ADDR = 12'h0357;
  // Gain array index of each trim; single-channel set starts at 4.
  localparam logic [2:0] GIDX_CA_B0 = 3'h0;
  localparam logic [2:0] GIDX_CA_B1 = 3'h1;
  localparam logic [2:0] GIDX_CB_B0 = 3'h2;
  localparam logic [2:0] GIDX_CB_B1 = 3'h3;
  localparam logic [2:0] GIDX_SINGLE = 3'h4;
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [3:0] OFS_RSVD_FUSE = 4'h0;
  localparam logic [2:0] GAIN_RSVD_FUSE = 3'h0;
  localparam logic [11:0] OFS_DISABLED = 12'h000;
  localparam logic [4:0] GAIN_DISABLED = 5'h00;
endpackage

// *** aogtb_trim_if.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Stored trim fields passed from the register bank to the selector.
// ****************************************************************
interface aogtb_trim_if;
  logic [1:0][11:0] offset;
  logic [7:0][4:0] gain;
  modport src (output offset, output gain);
  modport dst (input offset, input gain);
endinterface

// *** aogtb_trim_select.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Routes the trim set that matches mode and input to the datapath.
// ****************************************************************
module aogtb_trim_select (
  input wire logic clk_sys,
  input wire logic reset,
  aogtb_trim_if.dst trims,
  input wire logic dual_mode,
  input wire logic coreb_input_sel,
  input wire logic fg_cal_en,
  output logic [11:0] coreb_offset,
  output logic [4:0] corea_gain_bank0,
  output logic [4:0] corea_gain_bank1,
  output logic [4:0] coreb_gain_bank0,
  output logic [4:0] coreb_gain_bank1
);
  wire [2:0] set_base = dual_mode ? 3'h0 : aogtb_pkg::GIDX_SINGLE;
  wire [11:0] next_coreb_offset =
    !fg_cal_en ? aogtb_pkg::OFS_DISABLED :
    trims.offset[coreb_input_sel];
  wire [4:0] next_ca0 = fg_cal_en ?
    trims.gain[set_base | aogtb_pkg::GIDX_CA_B0] : aogtb_pkg::GAIN_DISABLED;
  wire [4:0] next_ca1 = fg_cal_en ?
    trims.gain[set_base | aogtb_pkg::GIDX_CA_B1] : aogtb_pkg::GAIN_DISABLED;
  wire [4:0] next_cb0 = fg_cal_en ?
    trims.gain[set_base | aogtb_pkg::GIDX_CB_B0] : aogtb_pkg::GAIN_DISABLED;
  wire [4:0] next_cb1 = fg_cal_en ?
    trims.gain[set_base | aogtb_pkg::GIDX_CB_B1] : aogtb_pkg::GAIN_DISABLED;

  // Raw field values go out unchanged while fg_cal_en is high and as zero while it is low, registered once.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      coreb_offset <= aogtb_pkg::OFS_DISABLED;
      corea_gain_bank0 <= aogtb_pkg::GAIN_DISABLED;
      corea_gain_bank1 <= aogtb_pkg::GAIN_DISABLED;
      coreb_gain_bank0 <= aogtb_pkg::GAIN_DISABLED;
      coreb_gain_bank1 <= aogtb_pkg::GAIN_DISABLED;
    end else begin
      coreb_offset <= next_coreb_offset;
      corea_gain_bank0 <= next_ca0;
      corea_gain_bank1 <= next_ca1;
      coreb_gain_bank0 <= next_cb0;
      coreb_gain_bank1 <= next_cb1;
    end
  end

  offset_input_sel_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fg_cal_en |=> coreb_offset == $past(trims.offset[coreb_input_sel]))
    else $error("core B offset does not follow selected input");
  dual_gain_route_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fg_cal_en && dual_mode |=> corea_gain_bank1 == $past(trims.gain[1])
    && coreb_gain_bank0 == $past(trims.gain[2]))
    else $error("dual mode gain trim misrouted");
  single_gain_route_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fg_cal_en && !dual_mode |=> corea_gain_bank0 == $past(trims.gain[4])
    && coreb_gain_bank1 == $past(trims.gain[7]))
    else $error("single mode gain trim misrouted");
  cal_off_zero_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !fg_cal_en |=> coreb_offset == aogtb_pkg::OFS_DISABLED
    && coreb_gain_bank0 == aogtb_pkg::GAIN_DISABLED)
    else $error("trim applied without foreground calibration");
endmodule // aogtb_trim_select

// *** aogtb_trim_bank.sv ***
`timescale 1ns/1ps
// Behaviour
// - Core B offset trim for input A sits in bits 11:0 of 0x34C.
// - Core B offset trim for input B sits in bits 11:0 of 0x34E.
// - The two core B offsets serve both dual and single channel modes.
// - Offset bits 15:12 are reserved, read/write, and reset to zero.
// - Every offset and gain trim is loaded from fuse memory values.
// - Dual mode uses core A bank gain trims at 0x350 and 0x351.
// - Dual mode uses core B bank gain trims at 0x352 and 0x353.
// - Single mode uses core A bank gain trims at 0x354 and 0x355.
// - Single mode uses core B bank gain trims at 0x356 and 0x357.
// - Gain trims sit in bits 4:0; bits 7:5 are reserved, writable, zero.
module aogtb_trim_bank (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic fuse_load,
  input wire logic [11:0] fuse_offset_input_a,
  input wire logic [11:0] fuse_offset_input_b,
  input wire logic [39:0] fuse_gain,
  input wire logic dual_mode,
  input wire logic coreb_input_sel,
  input wire logic fg_cal_en,
  output logic [11:0] coreb_offset,
  output logic [4:0] corea_gain_bank0,
  output logic [4:0] corea_gain_bank1,
  output logic [4:0] coreb_gain_bank0,
  output logic [4:0] coreb_gain_bank1
);
  // ****************************************************************
  // Address decode.
  // ****************************************************************
  logic [15:0] offset_trim [2];
  logic [7:0] gain_trim [8];

  function automatic logic ofs_hit(input logic [11:0] a);
    return a[11:2] == aogtb_pkg::OFS_INPUT_A_ADDR[11:2];
  endfunction

  function automatic logic gain_hit(input logic [11:0] a);
    return a[11:3] == aogtb_pkg::GAIN_CA_B0_DUAL_ADDR[11:3];
  endfunction

  wire wr_ofs = reg_wr_en && ofs_hit(reg_addr);
  wire wr_gain = reg_wr_en && gain_hit(reg_addr);
  wire ofs_idx = reg_addr[1];
  wire ofs_high = reg_addr[0];
  wire [2:0] gain_idx = reg_addr[2:0];
  wire [7:0] ofs_byte = ofs_high ? offset_trim[ofs_idx][15:8] :
    offset_trim[ofs_idx][7:0];
  wire [7:0] next_rdata = ofs_hit(reg_addr) ? ofs_byte :
    gain_hit(reg_addr) ? gain_trim[gain_idx] : aogtb_pkg::RDATA_UNMAPPED;

  // ****************************************************************
  // Trim storage.
  // ****************************************************************
  // A fuse load overrides a host write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < aogtb_pkg::NUM_OFS; i++) begin
        offset_trim[i] <= aogtb_pkg::OFS_RESET;
      end
      for (int i = 0; i < aogtb_pkg::NUM_GAIN; i++) begin
        gain_trim[i] <= aogtb_pkg::GAIN_RESET;
      end
    end else if (fuse_load) begin
      offset_trim[0] <= {aogtb_pkg::OFS_RSVD_FUSE, fuse_offset_input_a};
      offset_trim[1] <= {aogtb_pkg::OFS_RSVD_FUSE, fuse_offset_input_b};
      for (int i = 0; i < aogtb_pkg::NUM_GAIN; i++) begin
        gain_trim[i] <= {aogtb_pkg::GAIN_RSVD_FUSE,
          fuse_gain[i*aogtb_pkg::GAIN_W +: aogtb_pkg::GAIN_W]};
      end
    end else if (wr_ofs) begin
      if (ofs_high) begin
        offset_trim[ofs_idx][15:8] <= reg_wdata;
      end else begin
        offset_trim[ofs_idx][7:0] <= reg_wdata;
      end
    end else if (wr_gain) begin
      gain_trim[gain_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= aogtb_pkg::RDATA_UNMAPPED;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd_en ? next_rdata : aogtb_pkg::RDATA_UNMAPPED;
      reg_rd_valid <= reg_rd_en;
    end
  end

  // ****************************************************************
  // Datapath routing.
  // ****************************************************************
  aogtb_trim_if trims ();

  always_comb begin
    for (int i = 0; i < aogtb_pkg::NUM_OFS; i++) begin
      trims.offset[i] = offset_trim[i][11:0];
    end
    for (int i = 0; i < aogtb_pkg::NUM_GAIN; i++) begin
      trims.gain[i] = gain_trim[i][4:0];
    end
  end

  aogtb_trim_select u_select (
    .clk_sys(clk_sys),
    .reset(reset),
    .trims(trims),
    .dual_mode(dual_mode),
    .coreb_input_sel(coreb_input_sel),
    .fg_cal_en(fg_cal_en),
    .coreb_offset(coreb_offset),
    .corea_gain_bank0(corea_gain_bank0),
    .corea_gain_bank1(corea_gain_bank1),
    .coreb_gain_bank0(coreb_gain_bank0),
    .coreb_gain_bank1(coreb_gain_bank1)
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************
  read_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd_en |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_en)))
    else $error("read answer not one cycle after request");
  fuse_load_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fuse_load |=> offset_trim[1] == {aogtb_pkg::OFS_RSVD_FUSE,
    $past(fuse_offset_input_b)}
    && gain_trim[7] == {aogtb_pkg::GAIN_RSVD_FUSE, $past(fuse_gain[39:35])})
    else $error("fuse values not loaded");
  ofs_rsvd_rw_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == 12'h034D |=>
    offset_trim[0][15:12] == $past(reg_wdata[7:4]))
    else $error("offset reserved bits not writable");
  gain_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CB_B1_DUAL_ADDR
    |=> gain_trim[3] == $past(reg_wdata))
    else $error("gain register write lost");
  offset_readback_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_rd_en && reg_addr == aogtb_pkg::OFS_INPUT_B_ADDR |=>
    reg_rdata == $past(offset_trim[1][7:0]))
    else $error("offset low byte readback wrong");
  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd_en && reg_addr == 12'h0358 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // The read answer must not linger or appear without a request.
  rd_idle_zero_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reg_rd_en |=> !reg_rd_valid
    && reg_rdata == aogtb_pkg::RDATA_UNMAPPED)
    else $error("read answer outside a read");
  reset_clear_a: assert property (
    @(posedge clk_sys)
    reset |=> offset_trim[0] == aogtb_pkg::OFS_RESET
    && offset_trim[1] == aogtb_pkg::OFS_RESET
    && gain_trim[0] == aogtb_pkg::GAIN_RESET
    && gain_trim[7] == aogtb_pkg::GAIN_RESET)
    else $error("trims not cleared by reset");
  ofs_a_low_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::OFS_INPUT_A_ADDR |=>
    offset_trim[0][7:0] == $past(reg_wdata))
    else $error("input A offset low byte write lost");
  ofs_b_high_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load
    && reg_addr == (aogtb_pkg::OFS_INPUT_B_ADDR | 12'h001) |=>
    offset_trim[1][15:8] == $past(reg_wdata))
    else $error("input B offset high byte write lost");
  ofs_high_keeps_low_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == 12'h034D |=>
    offset_trim[0][7:0] == $past(offset_trim[0][7:0]))
    else $error("high byte write disturbed low byte");
  gain_dual_a0_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CA_B0_DUAL_ADDR
    |=> gain_trim[0] == $past(reg_wdata))
    else $error("dual core A bank 0 gain write lost");
  gain_dual_a1_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CA_B1_DUAL_ADDR
    |=> gain_trim[1] == $past(reg_wdata))
    else $error("dual core A bank 1 gain write lost");
  gain_dual_b0_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CB_B0_DUAL_ADDR
    |=> gain_trim[2] == $past(reg_wdata))
    else $error("dual core B bank 0 gain write lost");
  gain_single_a0_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CA_B0_SINGLE_ADDR
    |=> gain_trim[4] == $past(reg_wdata))
    else $error("single core A bank 0 gain write lost");
  gain_single_a1_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CA_B1_SINGLE_ADDR
    |=> gain_trim[5] == $past(reg_wdata))
    else $error("single core A bank 1 gain write lost");
  gain_single_b0_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CB_B0_SINGLE_ADDR
    |=> gain_trim[6] == $past(reg_wdata))
    else $error("single core B bank 0 gain write lost");
  gain_single_b1_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && reg_addr == aogtb_pkg::GAIN_CB_B1_SINGLE_ADDR
    |=> gain_trim[7] == $past(reg_wdata))
    else $error("single core B bank 1 gain write lost");
  gain_readback_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_rd_en && gain_hit(reg_addr) |=>
    reg_rdata == $past(gain_trim[gain_idx]))
    else $error("gain register readback wrong");
  fuse_beats_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fuse_load && reg_wr_en && reg_addr == aogtb_pkg::GAIN_CA_B0_DUAL_ADDR
    |=> gain_trim[0] == {aogtb_pkg::GAIN_RSVD_FUSE, $past(fuse_gain[4:0])})
    else $error("host write beat a fuse load");
  unmapped_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_wr_en && !fuse_load && !ofs_hit(reg_addr) && !gain_hit(reg_addr)
    |=> offset_trim[0] == $past(offset_trim[0])
    && gain_trim[0] == $past(gain_trim[0]))
    else $error("unmapped write changed a trim");
endmodule // aogtb_trim_bank

// *** aogtb_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Host end of the byte register port.
// ****************************************************************
module aogtb_host_model (
  input wire logic clk_sys,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule // aogtb_host_model

// *** aogtb_trim_bank_tb.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the trim bank.
// ****************************************************************
module aogtb_trim_bank_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fuse_load = 1'b0;
  logic dual_mode = 1'b0;
  logic coreb_input_sel = 1'b0;
  logic fg_cal_en = 1'b0;
  logic [11:0] fuse_offset_input_a = 12'hA5C;
  logic [11:0] fuse_offset_input_b = 12'h3E1;
  logic [39:0] fuse_gain = 40'h8C_A53E_1F7B;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [11:0] reg_addr, coreb_offset;
  logic [7:0] reg_wdata, reg_rdata;
  logic [4:0] ga0, ga1, gb0, gb1;
  logic [7:0] shadow [12];
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  aogtb_host_model i_host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
  aogtb_trim_bank i_dut (.clk_sys(clk_sys), .reset(reset),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .fuse_load(fuse_load),
    .fuse_offset_input_a(fuse_offset_input_a),
    .fuse_offset_input_b(fuse_offset_input_b), .fuse_gain(fuse_gain),
    .dual_mode(dual_mode), .coreb_input_sel(coreb_input_sel),
    .fg_cal_en(fg_cal_en), .coreb_offset(coreb_offset),
    .corea_gain_bank0(ga0), .corea_gain_bank1(ga1),
    .coreb_gain_bank0(gb0), .coreb_gain_bank1(gb1));

  task automatic give_verdict();
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hung wait is cut off well past the expected run length.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_out({16'h0000, got}, {16'h0000, exp});
  endtask

  task automatic check_all();
    logic [7:0] d;
    logic v;
    for (int i = 0; i < 13; i++) begin
      i_host.rd(12'h34C + 12'(i), d, v);
      chk_reg({7'h00, v}, 8'h01);
      chk_reg(d, (i < 12) ? shadow[i] : 8'h00);
    end
  endtask

  task automatic t_reset(input int n);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (n) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) shadow[i] = 8'h00;
    check_all();
  endtask

  task automatic t_rw();
    for (int i = 0; i < 12; i++) begin
      shadow[i] = 8'hA3 + 8'(i) * 8'h1D;
      i_host.wr(12'h34C + 12'(i), shadow[i]);
    end
    i_host.wr(12'h358, 8'hFF);
    check_all();
  endtask

  task automatic t_fuse();
    fork
      begin
        @(posedge clk_sys);
        fuse_load <= 1'b1;
        @(posedge clk_sys);
        fuse_load <= 1'b0;
      end
      i_host.wr(12'h350, 8'hFF);
    join
    shadow[0] = fuse_offset_input_a[7:0];
    shadow[1] = {4'h0, fuse_offset_input_a[11:8]};
    shadow[2] = fuse_offset_input_b[7:0];
    shadow[3] = {4'h0, fuse_offset_input_b[11:8]};
    for (int i = 0; i < 8; i++) shadow[4 + i] = {3'h0, fuse_gain[5*i +: 5]};
    check_all();
  endtask

  task automatic t_route();
    logic [11:0] ofs;
    logic [19:0] g;
    int k;
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys);
      dual_mode <= m[2];
      coreb_input_sel <= m[1];
      fg_cal_en <= ~m[0];
      repeat (2) @(posedge clk_sys);
      #1;
      k = m[2] ? 4 : 8;
      ofs = m[1] ? {shadow[3][3:0], shadow[2]} : {shadow[1][3:0], shadow[0]};
      g = {shadow[k][4:0], shadow[k+1][4:0], shadow[k+2][4:0],
           shadow[k+3][4:0]};
      if (m[0]) begin
        ofs = 12'h000;
        g = 20'h0_0000;
      end
      chk_out({12'h000, coreb_offset}, {12'h000, ofs});
      chk_out({4'h0, ga0, ga1, gb0, gb1}, {4'h0, g});
    end
  endtask

  initial begin
    t_reset(20);
    t_route();
    t_rw();
    t_route();
    t_fuse();
    t_route();
    t_reset(2);
    give_verdict();
  end
endmodule // aogtb_trim_bank_tb
